// File: hdl/capacitive_touch_result_regs.sv
`timescale 1ns/1ps
`include "touch_result_consts.svh"

module capacitive_touch_result_regs (
  input  wire logic                          sys_clk,     // 25 MHz clock
  input  wire logic                          rst,         // Async reset, high
  input  wire logic [`ADDR_W-1:0]            addr,        // Register byte address
  input  wire logic [31:0]                   wrData,      // Write data
  input  wire logic                          wrEn,        // Write strobe
  input  wire logic                          rdEn,        // Read strobe
  output logic      [31:0]                   rdData,      // Read data, next cycle
  input  wire logic                          sampleValid, // New sample pulse
  input  wire touch_result_pkg::sample_t     sample,      // Sample positions
  input  wire logic                          frameDone,   // Last line scanned out
  input  wire touch_result_pkg::tags_t       tagIn,       // Tag lookup results
  output logic                               samplingOn,  // Engine run enable
  output logic                               compatMode   // Single-touch mode
);

  // ==========================================================================
  // Control registers
  logic [1:0] samplingCtl_r;
  logic       detectMode_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samplingCtl_r <= `RST_SAMPLING_CTL;
    end else if (wrEn && addr == `OFS_SAMPLING_CTL) begin
      samplingCtl_r <= wrData[1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      detectMode_r <= `RST_DETECT_MODE;
    end else if (wrEn && addr == `OFS_DETECT_MODE) begin
      detectMode_r <= wrData[0];
    end
  end

  // Undefined encodings treated as running
  assign samplingOn = (samplingCtl_r != `SAMPLING_OFF);
  assign compatMode = (detectMode_r == `MODE_COMPAT);

  logic takeSample;
  assign takeSample = sampleValid && samplingOn;

  // ==========================================================================
  // Coordinate registers
  touch_result_pkg::point_t p1Coord_r;
  touch_result_pkg::point_t p1TagCoord_r;
  touch_result_pkg::point_t p2Coord_r;
  touch_result_pkg::point_t p3Coord_r;
  touch_result_pkg::point_t p4Coord_r;
  logic [15:0]              p5X_r;
  logic [15:0]              p5Y_r;
  touch_result_pkg::point_t raw_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p1Coord_r    <= `RST_COORD;
      p1TagCoord_r <= `RST_COORD;
    end else if (takeSample) begin
      p1Coord_r    <= sample.pts[0];
      p1TagCoord_r <= sample.tagPt;
    end
  end

  // Extra points only tracked in extended mode, else idle value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p2Coord_r <= `RST_COORD;
      p3Coord_r <= `RST_COORD;
      p4Coord_r <= `RST_COORD;
    end else if (compatMode) begin
      p2Coord_r <= `RST_COORD;
      p3Coord_r <= `RST_COORD;
      p4Coord_r <= `RST_COORD;
    end else if (takeSample) begin
      p2Coord_r <= sample.pts[1];
      p3Coord_r <= sample.pts[2];
      p4Coord_r <= sample.pts[3];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p5X_r <= `RST_HALF;
      p5Y_r <= `RST_HALF;
    end else if (compatMode) begin
      p5X_r <= `RST_HALF;
      p5Y_r <= `RST_HALF;
    end else if (takeSample) begin
      p5X_r <= sample.pts[4].x;
      p5Y_r <= sample.pts[4].y;
    end
  end

  // Raw position before calibration, compatibility mode only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_r <= `RST_RAW;
    end else if (takeSample && compatMode) begin
      raw_r <= sample.raw;
    end
  end

  // ==========================================================================
  // Tag registers
  logic [7:0] tag1_r;
  logic [7:0] tag2_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tag1_r <= `RST_TAG;
    end else if (frameDone) begin
      tag1_r <= tagIn.tag1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tag2_r <= `RST_TAG;
    end else if (frameDone) begin
      tag2_r <= compatMode ? `RST_TAG : tagIn.tag2;
    end
  end

  // ==========================================================================
  // Read path
  logic [31:0] rdData_nxt;

  always_comb begin
    rdData_nxt = 32'h00000000;
    unique case (addr)
      `OFS_SAMPLING_CTL: rdData_nxt = {30'h00000000, samplingCtl_r};
      `OFS_DETECT_MODE:  rdData_nxt = {31'h00000000, detectMode_r};
      `OFS_RAW_COORD:    rdData_nxt = raw_r;
      `OFS_P5_Y:         rdData_nxt = {16'h0000, p5Y_r};
      `OFS_P1_COORD:     rdData_nxt = p1Coord_r;
      `OFS_P1_TAG_COORD: rdData_nxt = p1TagCoord_r;
      `OFS_P1_TAG:       rdData_nxt = {24'h000000, tag1_r};
      `OFS_P2_TAG:       rdData_nxt = {24'h000000, tag2_r};
      `OFS_P5_X:         rdData_nxt = {16'h0000, p5X_r};
      `OFS_P2_COORD:     rdData_nxt = p2Coord_r;
      `OFS_P3_COORD:     rdData_nxt = p3Coord_r;
      `OFS_P4_COORD:     rdData_nxt = p4Coord_r;
      default:           rdData_nxt = 32'h00000000;
    endcase
  end

  // Reads change nothing but the read data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else if (rdEn) begin
      rdData <= rdData_nxt;
    end else begin
      rdData <= 32'h00000000;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  p2_layout_a: assert property (
    rdEn && addr == `OFS_P2_COORD |=> rdData == {$past(p2Coord_r.x), $past(p2Coord_r.y)})
    else $error("point two read mismatch");

  p3_capture_a: assert property (
    takeSample && !compatMode |=> p3Coord_r == $past(sample.pts[2]))
    else $error("point three not captured");

  p4_read_a: assert property (
    rdEn && addr == 12'h190 |=> rdData == $past(p4Coord_r))
    else $error("point four read mismatch");

  extra_idle_a: assert property (
    compatMode ##1 compatMode |-> p2Coord_r == 32'h80008000 && p5X_r == 16'h8000)
    else $error("extra point not idle in compatibility");

  p5x_read_a: assert property (
    rdEn && addr == 12'h16c |=> rdData[31:16] == 16'h0000 && rdData[15:0] == $past(p5X_r))
    else $error("point five X read wrong");

  p5y_capture_a: assert property (
    takeSample && !compatMode |=> p5Y_r == $past(sample.pts[4].y))
    else $error("point five Y not captured");

  raw_hold_a: assert property (
    !compatMode |=> $stable(raw_r))
    else $error("raw changed in extended mode");

  tag_frame_a: assert property (
    !frameDone |=> $stable(tag1_r) && $stable(tag2_r))
    else $error("tag changed outside frame end");

  tag1_load_a: assert property (
    frameDone |=> tag1_r == $past(tagIn.tag1))
    else $error("primary tag not refreshed");

  tag2_compat_a: assert property (
    frameDone && compatMode |=> tag2_r == 8'h00)
    else $error("second tag set in compatibility");

  tag_read_a: assert property (
    rdEn && addr == 12'h12c |=> rdData == {24'h000000, $past(tag1_r)})
    else $error("primary tag read wrong");

  mode_write_a: assert property (
    wrEn && addr == 12'h108 |=> compatMode == $past(wrData[0]))
    else $error("detection mode write lost");

  off_stop_a: assert property (
    samplingCtl_r == 2'h0 |=> $stable(p1Coord_r))
    else $error("sample taken while stopped");

  p1_capture_a: assert property (
    takeSample |=> p1Coord_r == $past(sample.pts[0]))
    else $error("point one not captured");

  idle_read_a: assert property (
    !rdEn |=> rdData == 32'h00000000)
    else $error("read data outside read slot");

  p2_capture_a: assert property (
    takeSample && !compatMode
    |=> p2Coord_r == $past(sample.pts[1]))
    else $error("point two not captured");

  p4_capture_a: assert property (
    takeSample && !compatMode
    |=> p4Coord_r == $past(sample.pts[3]))
    else $error("point four not captured");

  p5x_capture_a: assert property (
    takeSample && !compatMode
    |=> p5X_r == $past(sample.pts[4].x))
    else $error("point five X not captured");

  p3_read_a: assert property (
    rdEn && addr == `OFS_P3_COORD
    |=> rdData == $past(p3Coord_r))
    else $error("point three read mismatch");

  p5y_read_a: assert property (
    rdEn && addr == `OFS_P5_Y
    |=> rdData == {16'h0000, $past(p5Y_r)})
    else $error("point five Y read wrong");

  raw_capture_a: assert property (
    takeSample && compatMode
    |=> raw_r == $past(sample.raw))
    else $error("raw position not captured");

  raw_read_a: assert property (
    rdEn && addr == `OFS_RAW_COORD
    |=> rdData == $past(raw_r))
    else $error("raw position read wrong");

  far_idle_a: assert property (
    compatMode ##1 compatMode
    |-> p3Coord_r == `RST_COORD && p4Coord_r == `RST_COORD && p5Y_r == `RST_HALF)
    else $error("far point not idle in compatibility");

  tag2_load_a: assert property (
    frameDone && !compatMode
    |=> tag2_r == $past(tagIn.tag2))
    else $error("second tag not refreshed");

  tag2_read_a: assert property (
    rdEn && addr == `OFS_P2_TAG
    |=> rdData == {24'h000000, $past(tag2_r)})
    else $error("second tag read wrong");

  p1_read_a: assert property (
    rdEn && addr == `OFS_P1_COORD
    |=> rdData == $past(p1Coord_r))
    else $error("point one read mismatch");

  p1_hold_a: assert property (
    !takeSample
    |=> $stable(p1Coord_r) && $stable(p1TagCoord_r))
    else $error("point one moved without sample");

  tagxy_capture_a: assert property (
    takeSample
    |=> p1TagCoord_r == $past(sample.tagPt))
    else $error("tag position not captured");

  tagxy_read_a: assert property (
    rdEn && addr == `OFS_P1_TAG_COORD
    |=> rdData == $past(p1TagCoord_r))
    else $error("tag position read wrong");

  ctl_write_a: assert property (
    wrEn && addr == `OFS_SAMPLING_CTL
    |=> samplingCtl_r == $past(wrData[1:0]))
    else $error("sampling control write lost");

  ctl_read_a: assert property (
    rdEn && addr == `OFS_SAMPLING_CTL
    |=> rdData == {30'h0, $past(samplingCtl_r)})
    else $error("sampling control read wrong");

  mode_read_a: assert property (
    rdEn && addr == `OFS_DETECT_MODE
    |=> rdData == {31'h0, $past(detectMode_r)})
    else $error("detection mode read wrong");

  mode_hold_a: assert property (
    !(wrEn && addr == `OFS_DETECT_MODE)
    |=> $stable(detectMode_r))
    else $error("detection mode changed unasked");

  ctl_hold_a: assert property (
    !(wrEn && addr == `OFS_SAMPLING_CTL)
    |=> $stable(samplingCtl_r))
    else $error("sampling control changed unasked");

  read_quiet_a: assert property (
    rdEn && !takeSample && !frameDone
    |=> $stable(p1Coord_r) && $stable(tag1_r) && $stable(tag2_r))
    else $error("read disturbed stored value");

  unmapped_read_a: assert property (
    rdEn && addr == 12'h200
    |=> rdData == 32'h00000000)
    else $error("unmapped read not zero");

  p5_hold_a: assert property (
    !takeSample && !compatMode
    |=> $stable(p5X_r) && $stable(p5Y_r))
    else $error("point five moved without sample");

  mid_hold_a: assert property (
    !takeSample && !compatMode
    |=> $stable(p2Coord_r) && $stable(p3Coord_r) && $stable(p4Coord_r))
    else $error("extra point moved without sample");

  raw_stop_a: assert property (
    samplingCtl_r == 2'h0
    |=> $stable(raw_r))
    else $error("raw taken while stopped");

endmodule // capacitive_touch_result_regs

// File: hdl/touch_result_consts.svh
`ifndef TOUCH_RESULT_CONSTS_SVH
`define TOUCH_RESULT_CONSTS_SVH

`define ADDR_W            12
`define OFS_SAMPLING_CTL  12'h104
`define OFS_DETECT_MODE   12'h108
`define OFS_RAW_COORD     12'h11c
`define OFS_P5_Y          12'h120
`define OFS_P1_COORD      12'h124
`define OFS_P1_TAG_COORD  12'h128
`define OFS_P1_TAG        12'h12c
`define OFS_P2_TAG        12'h134
`define OFS_P5_X          12'h16c
`define OFS_P2_COORD      12'h170
`define OFS_P3_COORD      12'h18c
`define OFS_P4_COORD      12'h190

`define RST_SAMPLING_CTL  2'h3
`define RST_DETECT_MODE   1'h1
`define RST_COORD         32'h80008000
`define RST_HALF          16'h8000
`define RST_RAW           32'h0fffffff
`define RST_TAG           8'h00
`define SAMPLING_OFF      2'h0
`define SAMPLING_ON       2'h3
`define MODE_EXTENDED     1'h0
`define MODE_COMPAT       1'h1

`endif

// File: hdl/touch_result_pkg.sv
package touch_result_pkg;

  // One calibrated or raw touch position
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } point_t;

  // Positions delivered by the touch engine with one sample
  typedef struct packed {
    point_t [4:0] pts;
    point_t       raw;
    point_t       tagPt;
  } sample_t;

  // Tag lookups from the renderer, taken at end of frame
  typedef struct packed {
    logic [7:0] tag1;
    logic [7:0] tag2;
  } tags_t;

endpackage

// File: tb/tb.sv
`timescale 1ns/1ps
`include "touch_result_consts.svh"

module tb;
  logic                        sys_clk     = 1'b0;
  logic                        rst         = 1'b1;
  logic [`ADDR_W-1:0]          addr        = '0;
  logic [31:0]                 wrData      = '0;
  logic                        wrEn        = 1'b0;
  logic                        rdEn        = 1'b0;
  logic [31:0]                 rdData;
  logic                        sampleValid = 1'b0;
  touch_result_pkg::sample_t   sample      = '0;
  logic                        frameDone   = 1'b0;
  touch_result_pkg::tags_t     tagIn       = '0;
  logic                        samplingOn;
  logic                        compatMode;
  int                          n_errors    = 0;
  int                          checks_done = 0;
  logic [`ADDR_W-1:0]          ofs [4]     = '{`OFS_P1_COORD, `OFS_P2_COORD, `OFS_P3_COORD,
                                               `OFS_P4_COORD};

  always #20 sys_clk = ~sys_clk;

  capacitive_touch_result_regs u_dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .sampleValid(sampleValid), .sample(sample), .frameDone(frameDone),
    .tagIn(tagIn), .samplingOn(samplingOn), .compatMode(compatMode));

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wrEn <= 1'b1; addr <= a; wrData <= d;
    @(posedge sys_clk);
    wrEn <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rdChk(input logic [`ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
    @(posedge sys_clk);
    rdEn <= 1'b1; addr <= a;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    @(negedge sys_clk);
    chk(nm, rdData, exp);
  endtask

  task automatic putSample(input logic [15:0] b);
    touch_result_pkg::sample_t s;
    for (int i = 0; i < 5; i++) s.pts[i] = {b + 16'(i), b + 16'h0100 + 16'(i)};
    s.raw   = {b, ~b};
    s.tagPt = {b + 16'h0010, b + 16'h0020};
    @(posedge sys_clk);
    sampleValid <= 1'b1; sample <= s;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
  endtask

  task automatic putFrame(input logic [7:0] t1, input logic [7:0] t2);
    @(posedge sys_clk);
    frameDone <= 1'b1; tagIn <= '{tag1: t1, tag2: t2};
    @(posedge sys_clk);
    frameDone <= 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic resetValues();
    chk("samplingOn", {31'h0, samplingOn}, 32'h1);
    chk("compatMode", {31'h0, compatMode}, 32'h1);
    rdChk(`OFS_SAMPLING_CTL, 32'h3, "ctl");
    rdChk(`OFS_DETECT_MODE, 32'h1, "mode");
    for (int i = 0; i < 4; i++) rdChk(ofs[i], `RST_COORD, "coord");
    rdChk(`OFS_P5_X, 32'h8000, "p5x");
    rdChk(`OFS_P5_Y, 32'h8000, "p5y");
    rdChk(`OFS_RAW_COORD, `RST_RAW, "raw");
    rdChk(`OFS_P1_TAG, 32'h0, "tag1");
    rdChk(`OFS_P2_TAG, 32'h0, "tag2");
    rdChk(12'h200, 32'h0, "unmapped");
  endtask

  task automatic compatRun();
    putSample(16'h0300);
    rdChk(`OFS_P1_COORD, 32'h03000400, "p1");
    rdChk(`OFS_RAW_COORD, 32'h0300fcff, "raw");
    for (int i = 1; i < 4; i++) rdChk(ofs[i], `RST_COORD, "idle");
    rdChk(`OFS_P5_X, 32'h8000, "p5x");
    putFrame(8'h11, 8'h22);
    rdChk(`OFS_P1_TAG, 32'h11, "tag1");
    rdChk(`OFS_P2_TAG, 32'h0, "tag2");
  endtask

  task automatic extendedRun();
    wr(`OFS_DETECT_MODE, 32'hfffffffe);
    chk("compatMode", {31'h0, compatMode}, 32'h0);
    rdChk(`OFS_DETECT_MODE, 32'h0, "mode");
    putSample(16'h0a00);
    for (int i = 0; i < 4; i++)
      rdChk(ofs[i], {16'h0a00 + 16'(i), 16'h0b00 + 16'(i)}, "coord");
    rdChk(`OFS_P5_X, 32'h00000a04, "p5x");
    rdChk(`OFS_P5_Y, 32'h00000b04, "p5y");
    rdChk(`OFS_P1_TAG_COORD, 32'h0a100a20, "tagxy");
    rdChk(`OFS_RAW_COORD, 32'h0300fcff, "raw");
    @(posedge sys_clk);
    tagIn <= '{tag1: 8'hff, tag2: 8'h01};
    rdChk(`OFS_P1_TAG, 32'h11, "tag1");
    putFrame(8'hff, 8'h01);
    rdChk(`OFS_P1_TAG, 32'hff, "tag1");
    rdChk(`OFS_P2_TAG, 32'h01, "tag2");
  endtask

  task automatic stoppedRun();
    wr(`OFS_SAMPLING_CTL, 32'h0);
    chk("samplingOn", {31'h0, samplingOn}, 32'h0);
    putSample(16'h5500);
    rdChk(`OFS_P1_COORD, 32'h0a000b00, "p1");
    wr(`OFS_P1_COORD, 32'h0);
    rdChk(`OFS_P1_COORD, 32'h0a000b00, "p1");
    rdChk(`OFS_P1_COORD, 32'h0a000b00, "p1");
    wr(`OFS_SAMPLING_CTL, 32'hfffffffd);
    chk("samplingOn", {31'h0, samplingOn}, 32'h1);
    rdChk(`OFS_SAMPLING_CTL, 32'h1, "ctl");
    wr(`OFS_SAMPLING_CTL, 32'h3);
    chk("samplingOn", {31'h0, samplingOn}, 32'h1);
  endtask

  task automatic midReset();
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    @(negedge sys_clk);
    chk("compatMode", {31'h0, compatMode}, 32'h1);
    rdChk(`OFS_P1_TAG, 32'h0, "tag1");
    rdChk(`OFS_P2_TAG, 32'h0, "tag2");
    rdChk(`OFS_P1_COORD, `RST_COORD, "p1");
  endtask

  // ==========================================
  // Verdict and sequencing
  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    resetValues();
    compatRun();
    extendedRun();
    stoppedRun();
    midReset();
    summarize();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
endmodule // tb
